// ### hw/rdsh_pkg.sv
// Shared constants and carrier types of the data handshake and quality control block.
// Assumes a single 200 MHz system clock and plain-port control from the surrounding device.

package rdsh_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ             = 200000;   // System clock rate in kHz.
	localparam int STROBE_MAX_MS       = 10;       // Longest time the strobe stays low.
	localparam int DATA_HOLD_MS        = 20;       // Least time block data stays unchanged.
	localparam int QUALITY_MAX_US      = 850;      // Longest quality measurement.
	localparam int PAUSE_END_MS        = 5;        // Loud time needed to end a pause.
	localparam int STROBE_MAX_CYC      = STROBE_MAX_MS * CLK_KHZ;          // Longest time, exact.
	localparam int DATA_HOLD_CYC       = DATA_HOLD_MS * CLK_KHZ;           // Least time, exact.
	localparam int QUALITY_MAX_CYC     = (QUALITY_MAX_US * CLK_KHZ) / 1000; // Longest time, rounds down.
	localparam int PAUSE_END_CYC       = PAUSE_END_MS * CLK_KHZ;           // Least time, exact.
	localparam int TIMER_W             = 24;       // Width of every long timer.

	// ----------------------------------------------------------------
	// Control byte field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_CONT_BIT       = 7;        // Continuous measurement select.
	localparam int CTRL_TRIG_BIT       = 6;        // Measurement trigger.
	localparam int CTRL_MODE_HI_BIT    = 1;        // Output mode select, high bit.
	localparam int CTRL_MODE_LO_BIT    = 0;        // Output mode select, low bit.
	localparam logic [7:0] CTRL_RESET  = 8'h00;    // Control byte after reset.
	localparam logic [2:0] OSC_RESET   = 3'h0;     // Oscillator select bits after reset.
	localparam logic [3:0] QUALITY_RESET = 4'h0;   // Quality result after reset.
	localparam logic [15:0] BLOCK_RESET = 16'h0000; // Output block after reset.

	// ----------------------------------------------------------------
	// Output modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RDSH_MODE_STANDARD = 2'h0,  // standard_output_mode
		RDSH_MODE_FAST_ID  = 2'h1,  // fast_id_search_mode
		RDSH_MODE_REDUCED  = 2'h2,  // reduced_request_mode
		RDSH_MODE_UNDEF    = 2'h3   // Undefined, treated as standard.
	} rdsh_mode_t;

	// Control fields decoded from the first control byte.
	typedef struct packed {
		logic       quality_continuous_sel;
		logic       quality_trigger_bit;
		rdsh_mode_t out_mode;
	} rdsh_ctrl_t;

	// Events from the block decoder, all one-cycle pulses except synced.
	typedef struct packed {
		logic        synced;          // Decoder is synchronised (level).
		logic        blk_new;         // A newly processed valid block.
		logic        blk_is_a;        // That block carries offset A.
		logic        seq_found;       // Two blocks in correct sequence found.
		logic        flywheel_loss;   // Flywheel overflow, search restarted.
		logic [15:0] blk_data;        // Processed block word.
	} rdsh_dec_t;

	// Events from the serial slave, one-cycle pulses.
	typedef struct packed {
		logic ctrl_write;    // First control byte acknowledged.
		logic osc_write;     // Third control byte acknowledged.
		logic block_read;    // Host finished reading block data.
		logic status_read;   // Host read the decoder status register.
	} rdsh_host_t;

endpackage

// ### hw/rdsh_quality_meas.sv
// Single-shot quality measurement timer.
// Assumes the noise threshold comparator is already synchronised to clk_sys.

`timescale 1ns/1ps
`default_nettype none

module rdsh_quality_meas #(
	parameter int MAX_CYC = rdsh_pkg::QUALITY_MAX_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       clk_en,
	input  wire logic       start,
	input  wire logic       thr_hit,
	output logic            busy,
	output logic            done,
	output logic [3:0]      result
);

	// ----------------------------------------------------------------
	// Step size: the measuring window is cut into sixteen slices.
	// ----------------------------------------------------------------
	localparam int STEP_CYC = ((MAX_CYC - 2) / 16 < 1) ? 1 : (MAX_CYC - 2) / 16; // Start and store cycles fit the limit.

	logic [rdsh_pkg::TIMER_W-1:0] step_cnt;       // Cycles within the current slice.
	logic [rdsh_pkg::TIMER_W-1:0] next_step_cnt;
	logic [4:0]                   slice;          // Slices elapsed so far.
	logic [4:0]                   next_slice;
	logic                         next_busy;
	logic                         next_done;
	logic [3:0]                   next_result;

	// Next-state logic. A fast threshold hit means heavy noise, so the result counts down with time.
	always_comb begin
		next_step_cnt = step_cnt;
		next_slice    = slice;
		next_busy     = busy;
		next_done     = 1'b0;
		next_result   = result;
		if (start && !busy) begin
			// A new run restarts from a discharged capacitor.
			next_busy     = 1'b1;
			next_step_cnt = '0;
			next_slice    = 5'h00;
		end else if (busy) begin
			if (thr_hit) begin
				// Threshold reached: store the time equivalent value.
				next_result = 4'hf - slice[3:0];
				next_busy   = 1'b0;
				next_done   = 1'b1;
			end else if (step_cnt == rdsh_pkg::TIMER_W'(STEP_CYC - 1)) begin
				next_step_cnt = '0;
				next_slice    = slice + 5'h01;
				if (slice == 5'h0f) begin
					// Window over without a hit: no noise, end within the limit.
					next_result = 4'h0;
					next_busy   = 1'b0;
					next_done   = 1'b1;
				end
			end else begin
				next_step_cnt = step_cnt + 1'b1;
			end
		end
	end

	// State registers.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			step_cnt <= '0;
			slice    <= 5'h00;
			busy     <= 1'b0;
			done     <= 1'b0;
			result   <= rdsh_pkg::QUALITY_RESET;
		end else if (clk_en) begin
			step_cnt <= next_step_cnt;
			slice    <= next_slice;
			busy     <= next_busy;
			done     <= next_done;
			result   <= next_result;
		end
	end

endmodule

`default_nettype wire

// ### hw/rdsh_ctrl.sv
// Top of the data handshake and quality control block.
// Assumes a block decoder and a serial slave on clk_sys that deliver one-cycle event pulses,
// and asynchronous pins for supply drop, slow oscillator, noise threshold and audio level.

`timescale 1ns/1ps
`default_nettype none

module rdsh_ctrl #(
	parameter int STROBE_MAX_CYC  = rdsh_pkg::STROBE_MAX_CYC,
	parameter int DATA_HOLD_CYC   = rdsh_pkg::DATA_HOLD_CYC,
	parameter int QUALITY_MAX_CYC = rdsh_pkg::QUALITY_MAX_CYC,
	parameter int PAUSE_END_CYC   = rdsh_pkg::PAUSE_END_CYC
) (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                clk_en,
	input  wire logic [7:0]          ctrl_byte,
	input  wire logic [2:0]          osc_sel_in,
	input  wire rdsh_pkg::rdsh_host_t host_ev,
	input  wire rdsh_pkg::rdsh_dec_t  dec_ev,
	input  wire logic                supply_drop_pin,
	input  wire logic                osc_slow_pin,
	input  wire logic                noise_thr_pin,
	input  wire logic                audio_loud_pin,
	output logic                     data_ready_strobe_low,
	output logic [15:0]              block_out,
	output logic                     overflow_flag,
	output logic                     reset_seen_flag,
	output logic                     quality_trigger_bit,
	output logic                     quality_continuous_sel,
	output logic [1:0]               out_mode,
	output logic [3:0]               quality_result_field,
	output logic                     pause_detect_out_low,
	output logic [2:0]               osc_sel,
	output logic                     iface_init
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int NPIN = 4;
	localparam logic [NPIN-1:0] PIN_IDLE = 4'h8; // Audio starts loud, so reset shows no false pause.
	logic [NPIN-1:0] pin_raw;   // Raw asynchronous pins.
	logic [NPIN-1:0] pin_s1;    // First stage, read only by the second.
	logic [NPIN-1:0] pin_s2;    // Second stage.
	logic [NPIN-1:0] pin_s3;    // Third stage.
	logic [NPIN-1:0] pin_val;   // Accepted level once stages two and three agree.
	logic [NPIN-1:0] next_pin_val;

	assign pin_raw = {audio_loud_pin, noise_thr_pin, osc_slow_pin, supply_drop_pin};

	// Three stage flops and a level flop per pin; a level counts once stages two and three agree, filtering one-cycle glitches.
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_comb begin
				next_pin_val[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_val[gi];
			end
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					pin_s1[gi]  <= PIN_IDLE[gi];
					pin_s2[gi]  <= PIN_IDLE[gi];
					pin_s3[gi]  <= PIN_IDLE[gi];
					pin_val[gi] <= PIN_IDLE[gi];
				end else if (clk_en) begin
					pin_s1[gi]  <= pin_raw[gi];
					pin_s2[gi]  <= pin_s1[gi];
					pin_s3[gi]  <= pin_s2[gi];
					pin_val[gi] <= next_pin_val[gi];
				end
			end
		end
	endgenerate

	logic supply_drop;   // Synchronised supply drop.
	logic osc_slow;      // Synchronised oscillator-below-400 Hz detect.
	logic noise_thr;     // Synchronised noise threshold.
	logic audio_loud;    // Synchronised audio-above-threshold.
	assign supply_drop = pin_val[0];
	assign osc_slow    = pin_val[1];
	assign noise_thr   = pin_val[2];
	assign audio_loud  = pin_val[3];

	// ----------------------------------------------------------------
	// Internal reset and configuration
	// ----------------------------------------------------------------
	logic soft_rst;            // Internal reset from supply drop or slow oscillator.
	logic rst_pending;         // A reset still has to be announced by a strobe.
	logic next_rst_pending;
	logic next_reset_seen;
	logic next_iface_init;
	logic [2:0] next_osc_sel;
	rdsh_pkg::rdsh_ctrl_t ctrl;   // Decoded stored control fields.
	rdsh_pkg::rdsh_ctrl_t next_ctrl;
	logic q_start;             // Start a quality run this cycle.
	logic strobe_fire;         // Strobe goes low this cycle.
	localparam logic [3:0] CTRL_INIT = {rdsh_pkg::CTRL_RESET[rdsh_pkg::CTRL_CONT_BIT:rdsh_pkg::CTRL_TRIG_BIT],
		rdsh_pkg::CTRL_RESET[rdsh_pkg::CTRL_MODE_HI_BIT:rdsh_pkg::CTRL_MODE_LO_BIT]};

	assign soft_rst = supply_drop | osc_slow;

	// Reset bookkeeping and control byte capture. The reset flag set wins over a status read.
	always_comb begin
		next_rst_pending = rst_pending;
		next_reset_seen  = reset_seen_flag;
		next_iface_init  = soft_rst; // Holds the interface registers in init and the data line released.
		next_osc_sel     = osc_sel;
		next_ctrl        = ctrl;
		if (host_ev.status_read) begin
			next_reset_seen = 1'b0;
		end
		if (soft_rst) begin
			// Interface registers and oscillator bits go back to defaults; host must reprogram.
			next_reset_seen  = 1'b1;
			next_rst_pending = 1'b1;
			next_osc_sel     = rdsh_pkg::OSC_RESET;
			next_ctrl        = rdsh_pkg::rdsh_ctrl_t'(CTRL_INIT);
		end else begin
			if (host_ev.osc_write) begin
				next_osc_sel = osc_sel_in;
			end
			if (host_ev.ctrl_write) begin
				// Taken in any cycle outside an internal reset. Bit 7 continuous, bit 6 trigger, bits 1..0 mode.
				next_ctrl.quality_continuous_sel = ctrl_byte[rdsh_pkg::CTRL_CONT_BIT];
				next_ctrl.quality_trigger_bit    = ctrl_byte[rdsh_pkg::CTRL_TRIG_BIT];
				next_ctrl.out_mode = rdsh_pkg::rdsh_mode_t'({ctrl_byte[rdsh_pkg::CTRL_MODE_HI_BIT],
					ctrl_byte[rdsh_pkg::CTRL_MODE_LO_BIT]});
			end
			if (q_start) begin
				next_ctrl.quality_trigger_bit = 1'b0; // Trigger reads back clear while running.
			end
			if (strobe_fire && rst_pending) begin
				next_rst_pending = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Quality measurement control
	// ----------------------------------------------------------------
	logic       q_busy;      // Measurement running.
	logic       q_done;      // Measurement finished, one cycle.
	logic [3:0] q_value;     // Result of the last finished run.
	logic       q_cont;      // Continuous runs armed.
	logic       next_q_cont;
	logic       q_req;       // A single run is requested but not yet begun.
	logic       next_q_req;
	logic [3:0] next_quality;

	// Start on a single trigger at once, or restart after each run in continuous mode.
	always_comb begin
		next_q_req   = q_req;
		next_q_cont  = q_cont;
		next_quality = quality_result_field;
		if (host_ev.ctrl_write && !soft_rst) begin
			// Single shot with 0/1; continuous with 1/1; stop with 0/0 lets the run finish.
			next_q_req  = ctrl_byte[rdsh_pkg::CTRL_TRIG_BIT];
			next_q_cont = ctrl_byte[rdsh_pkg::CTRL_CONT_BIT] & ctrl_byte[rdsh_pkg::CTRL_TRIG_BIT];
		end
		if (q_start) begin
			next_q_req = 1'b0;
		end
		if (q_done) begin
			next_quality = q_value; // Latest finished value overwrites the stored one.
		end
		if (soft_rst) begin
			next_q_req   = 1'b0;
			next_q_cont  = 1'b0;
			next_quality = rdsh_pkg::QUALITY_RESET;
		end
	end

	// A run already in progress blocks a new start, so a stop never cuts it short.
	assign q_start = !q_busy && !soft_rst && (q_req || (q_cont && q_done));

	rdsh_quality_meas #(
		.MAX_CYC (QUALITY_MAX_CYC)
	) u_quality (
		.clk_sys (clk_sys),
		.rst     (rst),
		.clk_en  (clk_en),
		.start   (q_start),
		.thr_hit (noise_thr),
		.busy    (q_busy),
		.done    (q_done),
		.result  (q_value)
	);

	// ----------------------------------------------------------------
	// Data ready strobe and block output
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RDSH_STB_IDLE = 2'b01,   // Strobe high.
		RDSH_STB_LOW  = 2'b10    // Strobe low, timer running.
	} rdsh_stb_t;

	rdsh_stb_t                    stb_state;
	rdsh_stb_t                    next_stb_state;
	logic [rdsh_pkg::TIMER_W-1:0] stb_cnt;       // Time since strobe went low.
	logic [rdsh_pkg::TIMER_W-1:0] next_stb_cnt;
	logic [rdsh_pkg::TIMER_W-1:0] hold_cnt;      // Remaining data hold time.
	logic [rdsh_pkg::TIMER_W-1:0] next_hold_cnt;
	logic                         pair_odd;      // One block of a reduced-mode pair seen.
	logic                         next_pair_odd;
	logic                         read_pending;  // Posted data not yet read by the host.
	logic                         next_read_pending;
	logic                         next_overflow;
	logic [15:0]                  next_block;
	logic                         blk_event;     // A block that would post new data.
	logic                         blk_take;      // Block data is captured this cycle.

	// Which decoder events post data, per output mode and synchronisation state.
	always_comb begin
		blk_event = 1'b0;
		if (dec_ev.seq_found) begin
			blk_event = 1'b1;
		end else if (!dec_ev.synced) begin
			blk_event = dec_ev.blk_new && dec_ev.blk_is_a && (ctrl.out_mode == rdsh_pkg::RDSH_MODE_FAST_ID);
		end else if (ctrl.out_mode == rdsh_pkg::RDSH_MODE_REDUCED) begin
			blk_event = dec_ev.blk_new && pair_odd;
		end else begin
			blk_event = dec_ev.blk_new;
		end
	end

	// New data is dropped while the strobe is low, the data hold runs, or overflow stands.
	assign blk_take    = blk_event && (stb_state == RDSH_STB_IDLE) && !overflow_flag && (hold_cnt == '0);
	assign strobe_fire = (stb_state == RDSH_STB_IDLE) && !soft_rst &&
		(blk_take || dec_ev.flywheel_loss || rst_pending);

	// Strobe timing, hold timer, pairing and overflow. Overflow set wins over the status read clear.
	always_comb begin
		next_stb_state    = stb_state;
		next_stb_cnt      = stb_cnt;
		next_hold_cnt     = (hold_cnt != '0) ? hold_cnt - 1'b1 : hold_cnt;
		next_pair_odd     = pair_odd;
		next_read_pending = read_pending;
		next_overflow     = overflow_flag;
		next_block        = block_out;
		if (dec_ev.blk_new && dec_ev.synced) begin
			next_pair_odd = !pair_odd;
		end
		if (!dec_ev.synced) begin
			next_pair_odd = 1'b0;
		end
		if (host_ev.block_read) begin
			next_read_pending = 1'b0;
		end
		if (host_ev.status_read) begin
			next_overflow = 1'b0;
		end
		if (dec_ev.synced && dec_ev.blk_new && read_pending) begin
			next_overflow = 1'b1; // Block came before the last one was read.
		end
		case (stb_state)
			RDSH_STB_IDLE: begin
				if (strobe_fire) begin
					next_stb_state = RDSH_STB_LOW;
					next_stb_cnt   = '0;
				end
			end
			RDSH_STB_LOW: begin
				// Release after the longest low time or once the host has read the data.
				if (host_ev.block_read || stb_cnt == rdsh_pkg::TIMER_W'(STROBE_MAX_CYC - 1)) begin
					next_stb_state = RDSH_STB_IDLE;
				end else begin
					next_stb_cnt = stb_cnt + 1'b1;
				end
			end
			default: begin
				next_stb_state = RDSH_STB_IDLE;
			end
		endcase
		if (blk_take && strobe_fire) begin
			next_block        = dec_ev.blk_data;
			next_read_pending = 1'b1;
			next_hold_cnt     = rdsh_pkg::TIMER_W'(DATA_HOLD_CYC);
		end
		if (soft_rst) begin
			next_stb_state    = RDSH_STB_IDLE;
			next_read_pending = 1'b0;
			next_overflow     = 1'b0;
			next_pair_odd     = 1'b0;
			next_hold_cnt     = '0;
			next_block        = rdsh_pkg::BLOCK_RESET;
		end
	end

	// ----------------------------------------------------------------
	// Pause output
	// ----------------------------------------------------------------
	logic [rdsh_pkg::TIMER_W-1:0] loud_cnt;      // Consecutive loud cycles during a pause.
	logic [rdsh_pkg::TIMER_W-1:0] next_loud_cnt;
	logic                         next_pause_low;

	// A pause starts on a quiet level; it ends only after a full loud stretch, so clicks do not end it.
	always_comb begin
		next_pause_low = pause_detect_out_low;
		next_loud_cnt  = '0;
		if (!audio_loud) begin
			next_pause_low = 1'b0;
		end else if (!pause_detect_out_low) begin
			if (loud_cnt == rdsh_pkg::TIMER_W'(PAUSE_END_CYC - 1)) begin
				next_pause_low = 1'b1;
			end else begin
				next_loud_cnt = loud_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	// Power-up reset marks the reset flag and queues the reset strobe.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rst_pending           <= 1'b1;
			reset_seen_flag       <= 1'b1;
			iface_init            <= 1'b1;
			osc_sel               <= rdsh_pkg::OSC_RESET;
			ctrl                  <= rdsh_pkg::rdsh_ctrl_t'(CTRL_INIT);
			q_req                 <= 1'b0;
			q_cont                <= 1'b0;
			quality_result_field  <= rdsh_pkg::QUALITY_RESET;
			stb_state             <= RDSH_STB_IDLE;
			stb_cnt               <= '0;
			hold_cnt              <= '0;
			pair_odd              <= 1'b0;
			read_pending          <= 1'b0;
			overflow_flag         <= 1'b0;
			block_out             <= rdsh_pkg::BLOCK_RESET;
			data_ready_strobe_low <= 1'b1;
			loud_cnt              <= '0;
			pause_detect_out_low  <= 1'b1;
		end else if (clk_en) begin
			rst_pending           <= next_rst_pending;
			reset_seen_flag       <= next_reset_seen;
			iface_init            <= next_iface_init;
			osc_sel               <= next_osc_sel;
			ctrl                  <= next_ctrl;
			q_req                 <= next_q_req;
			q_cont                <= next_q_cont;
			quality_result_field  <= next_quality;
			stb_state             <= next_stb_state;
			stb_cnt               <= next_stb_cnt;
			hold_cnt              <= next_hold_cnt;
			pair_odd              <= next_pair_odd;
			read_pending          <= next_read_pending;
			overflow_flag         <= next_overflow;
			block_out             <= next_block;
			data_ready_strobe_low <= (next_stb_state != RDSH_STB_LOW);
			loud_cnt              <= next_loud_cnt;
			pause_detect_out_low  <= next_pause_low;
		end
	end

	// Mirrors of stored control fields; continuous select is a flop copy of the control byte.
	always_comb begin
		quality_trigger_bit    = ctrl.quality_trigger_bit;
		quality_continuous_sel = ctrl.quality_continuous_sel;
		out_mode               = ctrl.out_mode;
	end

endmodule

`default_nettype wire

// ### bench/rdsh_host_model.sv
// Host controller model: reads block and status a few cycles after the ready strobe falls.
// Assumes it runs on clk_sys of the handshake block.
`timescale 1ns/1ps
`default_nettype none
module rdsh_host_model (
	input  wire logic clk_sys,
	input  wire logic strobe_low,
	input  wire logic slow,
	output logic      rd
);
	int n = 0; // Cycles since the strobe fell.
	// A slow host never reads, so the block must release the strobe on its own.
	always @(posedge clk_sys) begin
		n <= strobe_low ? 0 : n + 1;
		rd <= !strobe_low && n == 3 && !slow;
	end
endmodule
`default_nettype wire

// ### bench/rdsh_ctrl_asserts.sv
// Checker of the handshake block, bound to the top ports.
// Assumes clk_en high and no host or decoder events during an internal reset.
`timescale 1ns/1ps
`default_nettype none
module rdsh_ctrl_asserts #(
	parameter int STROBE_MAX_CYC = 50
) (
	input wire logic                 clk_sys,
	input wire logic                 rst,
	input wire logic                 clk_en,
	input wire logic [7:0]           ctrl_byte,
	input wire rdsh_pkg::rdsh_host_t host_ev,
	input wire rdsh_pkg::rdsh_dec_t  dec_ev,
	input wire logic                 data_ready_strobe_low,
	input wire logic [15:0]          block_out,
	input wire logic                 overflow_flag,
	input wire logic                 reset_seen_flag,
	input wire logic                 quality_trigger_bit,
	input wire logic [1:0]           out_mode
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	int lo; // Cycles the strobe has stayed low.
	// A counter keeps the long limit out of a repetition.
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			lo <= 0;
		else if (clk_en)
			lo <= data_ready_strobe_low ? 0 : lo + 1;
	a_strobe_limit: assert property (lo <= STROBE_MAX_CYC)
		else $error("strobe low too long");
	a_read_release: assert property (clk_en && !data_ready_strobe_low && host_ev.block_read |=> data_ready_strobe_low)
		else $error("strobe kept after read");
	a_hold_data: assert property ($fell(data_ready_strobe_low) |=> $stable(block_out)[*8])
		else $error("block changed while posted");
	a_drop_busy: assert property (clk_en && !data_ready_strobe_low && dec_ev.blk_new |=> $stable(block_out))
		else $error("block taken while strobe low");
	a_ovf_freeze: assert property (clk_en && overflow_flag && dec_ev.blk_new |=> $stable(block_out))
		else $error("block taken during overflow");
	a_ovf_cause: assert property ($rose(overflow_flag) |-> $past(dec_ev.blk_new))
		else $error("overflow without block");
	a_flag_clear: assert property (clk_en && reset_seen_flag && host_ev.status_read |=> !reset_seen_flag)
		else $error("reset flag kept after read");
	a_trig_clear: assert property (clk_en && host_ev.ctrl_write && ctrl_byte[7:6] == 2'h1 |=> ##1 !quality_trigger_bit)
		else $error("trigger bit kept");
	a_mode_take: assert property (clk_en && host_ev.ctrl_write |=> out_mode == $past(ctrl_byte[1:0]))
		else $error("mode not taken");
	cover property ($fell(data_ready_strobe_low));
	cover property ($rose(overflow_flag));
	cover property ($fell(quality_trigger_bit));
endmodule
`default_nettype wire

// ### bench/rdsh_ctrl_tb.sv
// Testbench of the handshake block with a host model on the strobe.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rdsh_ctrl_tb;
	logic clk_sys = 0, rst = 1, clk_en = 1, supply_drop_pin = 0, osc_slow_pin = 0, noise_thr_pin = 0;
	logic audio_loud_pin = 1, cw = 0, ow = 0, sr = 0, slow = 0, rd, data_ready_strobe_low, overflow_flag;
	logic reset_seen_flag, quality_trigger_bit, quality_continuous_sel, pause_detect_out_low, iface_init;
	logic [7:0] ctrl_byte = 0;
	logic [2:0] osc_sel_in = 0, osc_sel;
	logic [1:0] out_mode;
	logic [3:0] quality_result_field;
	logic [15:0] block_out, d;
	rdsh_pkg::rdsh_dec_t dec_ev = '0;
	rdsh_pkg::rdsh_host_t host_ev;
	int seed = 84, fail_count = 0, tests_run = 0, cyc = 0;
	assign host_ev = {cw, ow, rd, rd | sr};
	rdsh_ctrl #(.STROBE_MAX_CYC(50), .DATA_HOLD_CYC(100), .QUALITY_MAX_CYC(160), .PAUSE_END_CYC(20)) dut (.*);
	rdsh_host_model host (.clk_sys, .strobe_low(data_ready_strobe_low), .slow, .rd);
	initial forever #2.5 clk_sys = ~clk_sys;
	// A hang counts as a mismatch and ends the run.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 8000) begin
			fail_count++;
			results();
		end
	end
	task automatic results();
		$display("compares %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Flags are synced, new, A-offset, sequence, flywheel loss; pulses last one cycle.
	task automatic blk(input logic [4:0] f, input logic [15:0] v);
		@(negedge clk_sys);
		dec_ev = {f, v};
		@(negedge clk_sys);
		dec_ev = {f[4], 4'h0, v};
	endtask
	task automatic wr(input logic [7:0] b);
		@(negedge clk_sys);
		ctrl_byte = b;
		cw = 1;
		@(negedge clk_sys);
		cw = 0;
	endtask
	// Whether a lone block {synced, new, A, sequence, loss} lowers the strobe in mode m, pair count at zero.
	function automatic logic strobes(input int m, input logic [4:0] f);
		if (f[1] || f[0])
			return 1'b1;
		return f[4] ? m != 2 : (f[3] && f[2] && m == 1);
	endfunction
	initial begin
		wt(10);
		rst = 0;
		wt(2);
		cmp(data_ready_strobe_low, 0);
		cmp(reset_seen_flag, 1);
		wt(8);
		cmp(reset_seen_flag, 0);
		osc_sel_in = 3'($random(seed));
		ow = 1;
		wt(1);
		ow = 0;
		cmp(osc_sel, osc_sel_in);
		$display("reset and oscillator done");
		wt(100);
		for (int m = 0; m < 3; m++) begin
			wr(8'(m));
			d = 16'($random(seed));
			blk(5'b01100, d);
			cmp(data_ready_strobe_low, !strobes(m, 5'b01100));
			wt(110);
			d = 16'($random(seed));
			blk(5'b01010, d);
			cmp(block_out, d);
			wt(110);
			blk(5'b00001, ~d);
			cmp(data_ready_strobe_low, 0);
			wt(110);
			blk(5'b11000, d);
			cmp(data_ready_strobe_low, !strobes(m, 5'b11000));
			wt(110);
			d = 16'($random(seed));
			blk(5'b11000, d);
			blk(5'b11000, ~d);
			cmp(block_out, d);
			cmp(overflow_flag, 1);
			wt(110);
			$display("output mode %0d done", m);
		end
		slow = 1;
		blk(5'b11000, d);
		wt(45);
		cmp(data_ready_strobe_low, 0);
		wt(10);
		cmp(data_ready_strobe_low, 1);
		wt(60);
		blk(5'b11000, ~d);
		blk(5'b11000, d + 16'h1);
		cmp(overflow_flag, 1);
		cmp(block_out, d);
		sr = 1;
		wt(1);
		sr = 0;
		cmp(overflow_flag, 0);
		slow = 0;
		$display("slow host done");
		noise_thr_pin = 1;
		wr(8'h40);
		wt(2);
		cmp(quality_trigger_bit, 0);
		wt(30);
		cmp(quality_result_field, 15);
		noise_thr_pin = 0;
		wr(8'hc0);
		cmp(quality_continuous_sel, 1);
		wt(200);
		cmp(quality_result_field, 0);
		wr(8'h00);
		wt(200);
		noise_thr_pin = 1;
		wt(200);
		cmp(quality_result_field, 0);
		$display("quality done");
		audio_loud_pin = 0;
		wt(10);
		cmp(pause_detect_out_low, 0);
		audio_loud_pin = 1;
		wt(15);
		cmp(pause_detect_out_low, 0);
		wt(15);
		cmp(pause_detect_out_low, 1);
		$display("pause done");
		// Supply drop, then slow oscillator: each is an internal reset in mid-run.
		for (int k = 1; k < 3; k++) begin
			{osc_slow_pin, supply_drop_pin} = 2'(k);
			wt(6);
			cmp(iface_init, 1);
			cmp(osc_sel, 0);
			{osc_slow_pin, supply_drop_pin} = 2'h0;
			wt(6);
			cmp(data_ready_strobe_low, 0);
			cmp(reset_seen_flag, 1);
			wt(10);
			cmp(reset_seen_flag, 0);
		end
		$display("internal reset done");
		results();
	end
endmodule
bind rdsh_ctrl rdsh_ctrl_asserts #(.STROBE_MAX_CYC(STROBE_MAX_CYC)) chk (.*);
`default_nettype wire
